// [hdl/eeprom_map.svh]
// Purpose: constants shared by both ends of the serial memory link
// Assumes: link clock 12 ns, system clock 10 ns
// Notes:   definitions only
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

`define EE_ADDR_W 15
`define EE_DEPTH 32768
`define EE_PAGE_BITS 6
`define EE_DEV_CODE 5'h14
`define EE_WRITE_CYCLE_NS 10000000
`define EE_LINK_PERIOD_NS 12
// longest wait, so round up
`define EE_WRITE_CYCLES ((`EE_WRITE_CYCLE_NS + `EE_LINK_PERIOD_NS - 1) / `EE_LINK_PERIOD_NS)
`define EE_CLK_PERIOD_NS 10
`define EE_SCL_PERIOD_NS 1000
`define EE_SCL_QUARTER (`EE_SCL_PERIOD_NS / (4 * `EE_CLK_PERIOD_NS))

`endif

// [hdl/eeprom_pkg.sv]
// Purpose: types shared by both ends
// Assumes: nothing
// Notes:   numbers live in eeprom_map.svh
package eeprom_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_RX = 3'h1,
    S_RXACK = 3'h2,
    S_TX = 3'h3,
    S_TXACK = 3'h4,
    S_WAITSTOP = 3'h5
  } slave_state_type;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_START = 3'h1,
    M_WBYTE = 3'h2,
    M_RBYTE = 3'h3,
    M_STOP = 3'h4
  } master_state_type;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_RAND_READ = 2'h1,
    OP_CUR_READ = 2'h2
  } op_type;
endpackage

// [hdl/eeprom_link_if.sv]
// Purpose: two-wire link between bus master and memory slave
// Assumes: both lines pulled up
// Notes:   each party only pulls low; enables resolve the level here
`timescale 1ns/100ps
interface eeprom_link_if;
  logic sclOe;
  logic sdaMasterOe;
  logic sdaSlaveOe;
  logic scl;
  logic sda;

  // wired-and with pull-up
  assign scl = ~sclOe;
  assign sda = ~(sdaMasterOe | sdaSlaveOe);

  modport master (output sclOe, output sdaMasterOe, input scl, input sda);
  modport slave (output sdaSlaveOe, input scl, input sda);
endinterface

// [hdl/eeprom_slave.sv]
// Purpose: memory slave end of the two-wire link, 32768 x 8 array
// Assumes: linkClk much faster than scl; master obeys framing
// Notes:   writes land in the array as acked, then busy time follows stop
//
// Functional notes
// - write protect makes array read only
// - protected: still ack slave and address bytes
// - protected: no ack on data, no programming
// - read starts like write, direction bit one
// - counter holds last accessed location plus one
// - counter wraps from 32767 to 0 on reads; on writes it wraps within the 64-byte page
// - read address acked, then byte shifted out
// - random read begins with a dummy write
// - repeated start plus read returns loaded byte
// - master ack brings the following byte
// - master nack ends the read, then stop
// - read increment covers all address bits
// - sequential read from either read kind
// - match fixed code and chip select bits
// - two address bytes load the counter
// - busy programming: bus ignored, no ack
// - after nack release data, await stop
`timescale 1ns/100ps
`include "eeprom_map.svh"

module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `EE_WRITE_CYCLES
) (
  input wire logic linkClk,
  input wire logic rst_n,
  eeprom_link_if.slave link,
  input wire logic writeProtect,
  input wire logic chip_select_bit0,
  input wire logic chip_select_bit1,
  output logic programBusy
);

  // ----------------------------------------
  // pin synchronisers, bit2 = write protect, bit1 = scl, bit0 = sda
  // ----------------------------------------
  logic [2:0] sync1_q, sync2_q, sync3_q;
  logic [2:0] filt_q, filt_d;
  logic [1:0] prev_q;

  // protect resets low; no data byte can arrive before the filter settles
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 3'h3;
      sync2_q <= 3'h3;
      sync3_q <= 3'h3;
    end else begin
      sync1_q <= {writeProtect, link.scl, link.sda};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a change counts only when the last two stages agree
  always_comb begin
    filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));
  end

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q <= 3'h3;
      prev_q <= 2'h3;
    end else begin
      filt_q <= filt_d;
      prev_q <= filt_q[1:0];
    end
  end

  logic sclRise, sclFall, startCond, stopCond, sdaIn, wpIn;
  assign sdaIn = filt_q[0];
  assign wpIn = filt_q[2];
  assign sclRise = filt_q[1] & ~prev_q[1];
  assign sclFall = ~filt_q[1] & prev_q[1];
  assign startCond = filt_q[1] & prev_q[1] & prev_q[0] & ~filt_q[0];
  assign stopCond = filt_q[1] & prev_q[1] & ~prev_q[0] & filt_q[0];

  // ----------------------------------------
  // storage array
  // ----------------------------------------
  logic [7:0] mem [0:`EE_DEPTH-1];
  logic memWe;
  logic [`EE_ADDR_W-1:0] addrCnt_q, addrCnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] memOut;

  assign memOut = mem[addrCnt_q];

  always_ff @(posedge linkClk) begin
    if (memWe) begin
      mem[addrCnt_q] <= shift_q;
    end
  end

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  slave_state_type state_q, state_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [1:0] byteIdx_q, byteIdx_d;
  logic [6:0] addrHi_q, addrHi_d;
  logic isRead_q, isRead_d;
  logic sdaOe_q, sdaOe_d;
  logic wrote_q, wrote_d;
  logic [31:0] busyCnt_q, busyCnt_d;
  logic busy_q, busy_d;
  logic [6:0] myAddr;
  logic [`EE_PAGE_BITS-1:0] pageNext;

  assign myAddr = {`EE_DEV_CODE, chip_select_bit1, chip_select_bit0};
  assign pageNext = addrCnt_q[`EE_PAGE_BITS-1:0] + 1'b1;

  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    byteIdx_d = byteIdx_q;
    addrHi_d = addrHi_q;
    addrCnt_d = addrCnt_q;
    shift_d = shift_q;
    isRead_d = isRead_q;
    sdaOe_d = sdaOe_q;
    wrote_d = wrote_q;
    busyCnt_d = busyCnt_q;
    memWe = 1'b0;
    if (busyCnt_q != 32'h0) begin
      // programming: deaf to the bus
      busyCnt_d = busyCnt_q - 32'h1;
      state_d = S_IDLE;
      sdaOe_d = 1'b0;
    end else if (stopCond) begin
      state_d = S_IDLE;
      sdaOe_d = 1'b0;
      if (wrote_q) begin
        busyCnt_d = WRITE_CYCLES;
        wrote_d = 1'b0;
      end
    end else if (startCond) begin
      state_d = S_RX;
      bitCnt_d = 4'h0;
      byteIdx_d = 2'h0;
      sdaOe_d = 1'b0;
    end else begin
      case (state_q)
        S_RX: begin
          if (sclRise) begin
            shift_d = {shift_q[6:0], sdaIn};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == 4'h8) begin
            byteIdx_d = (byteIdx_q == 2'h3) ? 2'h3 : byteIdx_q + 2'h1;
            state_d = S_RXACK;
            sdaOe_d = 1'b1;
            case (byteIdx_q)
              2'h0: begin
                if (shift_q[7:1] == myAddr) begin
                  isRead_d = shift_q[0];
                end else begin
                  state_d = S_WAITSTOP;
                  sdaOe_d = 1'b0;
                end
              end
              2'h1: addrHi_d = shift_q[6:0];
              2'h2: addrCnt_d = {addrHi_q, shift_q};
              default: begin
                if (wpIn) begin
                  state_d = S_WAITSTOP;
                  sdaOe_d = 1'b0;
                end else begin
                  memWe = 1'b1;
                  wrote_d = 1'b1;
                  addrCnt_d = {addrCnt_q[`EE_ADDR_W-1:`EE_PAGE_BITS], pageNext};
                end
              end
            endcase
          end
        end
        S_RXACK: begin
          if (sclFall) begin
            if (isRead_q && byteIdx_q == 2'h1) begin
              shift_d = memOut;
              addrCnt_d = addrCnt_q + 1'b1;
              sdaOe_d = ~memOut[7];
              bitCnt_d = 4'h1;
              state_d = S_TX;
            end else begin
              sdaOe_d = 1'b0;
              bitCnt_d = 4'h0;
              state_d = S_RX;
            end
          end
        end
        S_TX: begin
          if (sclFall) begin
            if (bitCnt_q == 4'h8) begin
              sdaOe_d = 1'b0;
              state_d = S_TXACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              sdaOe_d = ~shift_q[6];
              bitCnt_d = bitCnt_q + 4'h1;
            end
          end
        end
        S_TXACK: begin
          if (sclRise && sdaIn) begin
            state_d = S_WAITSTOP;
          end else if (sclFall) begin
            shift_d = memOut;
            addrCnt_d = addrCnt_q + 1'b1;
            sdaOe_d = ~memOut[7];
            bitCnt_d = 4'h1;
            state_d = S_TX;
          end
        end
        S_WAITSTOP: sdaOe_d = 1'b0;
        default: state_d = S_IDLE;
      endcase
    end
    busy_d = busyCnt_d != 32'h0;
  end

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      bitCnt_q <= 4'h0;
      byteIdx_q <= 2'h0;
      addrHi_q <= 7'h00;
      addrCnt_q <= 15'h0000;
      shift_q <= 8'h00;
      isRead_q <= 1'b0;
      sdaOe_q <= 1'b0;
      wrote_q <= 1'b0;
      busyCnt_q <= 32'h0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      byteIdx_q <= byteIdx_d;
      addrHi_q <= addrHi_d;
      addrCnt_q <= addrCnt_d;
      shift_q <= shift_d;
      isRead_q <= isRead_d;
      sdaOe_q <= sdaOe_d;
      wrote_q <= wrote_d;
      busyCnt_q <= busyCnt_d;
      busy_q <= busy_d;
    end
  end

  assign link.sdaSlaveOe = sdaOe_q;
  assign programBusy = busy_q;

endmodule

// [hdl/eeprom_master.sv]
// Purpose: bus master end, turns user commands into link transactions
// Assumes: one command at a time; cmdLen 0 reads one byte
// Notes:   scl derived from clk by a quarter-period divider
`timescale 1ns/100ps
`include "eeprom_map.svh"

module eeprom_master
  import eeprom_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  eeprom_link_if.master link,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire op_type cmdOp,
  input wire logic [1:0] cmdChip,
  input wire logic [`EE_ADDR_W-1:0] cmdAddr,
  input wire logic [7:0] cmdData,
  input wire logic [7:0] cmdLen,
  output logic rdValid,
  output logic [7:0] rdData,
  output logic done,
  output logic nack
);

  // ----------------------------------------
  // sda synchroniser
  // ----------------------------------------
  logic [2:0] sdaSync_q;
  logic sdaF_q, sdaF_d;

  always_comb begin
    sdaF_d = (sdaSync_q[1] == sdaSync_q[2]) ? sdaSync_q[1] : sdaF_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdaSync_q <= 3'h7;
      sdaF_q <= 1'b1;
    end else begin
      sdaSync_q <= {sdaSync_q[1:0], link.sda};
      sdaF_q <= sdaF_d;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  localparam logic [7:0] QTR_LAST = 8'(`EE_SCL_QUARTER - 1);

  master_state_type state_q, state_d;
  op_type op_q, op_d;
  logic [7:0] tick_q, tick_d;
  logic [1:0] qtr_q, qtr_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] tx_q, tx_d, rx_q, rx_d, left_q, left_d;
  logic [1:0] wIdx_q, wIdx_d, chip_q, chip_d;
  logic rdPhase_q, rdPhase_d, slvNack_q, slvNack_d;
  logic [`EE_ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] data_q, data_d, rdData_d;
  logic sclOe_q, sclOe_d, sdaOe_q, sdaOe_d;
  logic rdValid_d, done_d, nack_d, tick, unitEnd, sclHi, sdaHi;

  assign tick = tick_q == QTR_LAST;
  assign unitEnd = tick && qtr_q == 2'h3;
  assign cmdReady = state_q == M_IDLE;

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    tick_d = tick ? 8'h00 : tick_q + 8'h01;
    qtr_d = tick ? qtr_q + 2'h1 : qtr_q;
    bit_d = bit_q;
    tx_d = tx_q;
    rx_d = rx_q;
    left_d = left_q;
    wIdx_d = wIdx_q;
    chip_d = chip_q;
    rdPhase_d = rdPhase_q;
    slvNack_d = slvNack_q;
    addr_d = addr_q;
    data_d = data_q;
    rdData_d = rdData;
    rdValid_d = 1'b0;
    done_d = 1'b0;
    nack_d = nack;
    case (state_q)
      M_IDLE: begin
        tick_d = 8'h00;
        qtr_d = 2'h0;
        if (cmdValid) begin
          state_d = M_START;
          op_d = cmdOp;
          chip_d = cmdChip;
          addr_d = cmdAddr;
          data_d = cmdData;
          left_d = (cmdLen == 8'h00) ? 8'h01 : cmdLen;
          rdPhase_d = cmdOp == OP_CUR_READ;
          wIdx_d = 2'h0;
          nack_d = 1'b0;
        end
      end
      M_START: begin
        if (unitEnd) begin
          state_d = M_WBYTE;
          bit_d = 4'h0;
          tx_d = {`EE_DEV_CODE, chip_q, rdPhase_q};
        end
      end
      M_WBYTE: begin
        if (tick && qtr_q == 2'h2 && bit_q == 4'h8) begin
          slvNack_d = sdaF_q;
        end
        if (unitEnd) begin
          bit_d = bit_q + 4'h1;
          tx_d = {tx_q[6:0], 1'b0};
          if (bit_q == 4'h8) begin
            bit_d = 4'h0;
            wIdx_d = wIdx_q + 2'h1;
            if (slvNack_q) begin
              nack_d = 1'b1;
              state_d = M_STOP;
            end else if (rdPhase_q) begin
              state_d = M_RBYTE;
            end else begin
              case (wIdx_q)
                2'h0: tx_d = {1'b0, addr_q[14:8]};
                2'h1: tx_d = addr_q[7:0];
                2'h2: begin
                  if (op_q == OP_WRITE) begin
                    tx_d = data_q;
                  end else begin
                    state_d = M_START;
                    rdPhase_d = 1'b1;
                  end
                end
                default: state_d = M_STOP;
              endcase
            end
          end
        end
      end
      M_RBYTE: begin
        if (tick && qtr_q == 2'h2 && bit_q != 4'h8) begin
          rx_d = {rx_q[6:0], sdaF_q};
        end
        if (unitEnd) begin
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'h7) begin
            rdValid_d = 1'b1;
            rdData_d = rx_q;
          end
          if (bit_q == 4'h8) begin
            bit_d = 4'h0;
            left_d = left_q - 8'h01;
            if (left_q == 8'h01) begin
              state_d = M_STOP;
            end
          end
        end
      end
      M_STOP: begin
        if (unitEnd) begin
          state_d = M_IDLE;
          done_d = 1'b1;
        end
      end
      default: state_d = M_IDLE;
    endcase
  end

  // line levels per quarter; registered one cycle later as enables
  always_comb begin
    case (state_q)
      M_START: begin
        sclHi = qtr_q != 2'h0;
        sdaHi = qtr_q < 2'h2;
      end
      M_STOP: begin
        sclHi = qtr_q != 2'h0;
        sdaHi = qtr_q >= 2'h2;
      end
      M_WBYTE: begin
        sclHi = qtr_q[1];
        sdaHi = (bit_q == 4'h8) | tx_q[7];
      end
      M_RBYTE: begin
        sclHi = qtr_q[1];
        // ack while more bytes are wanted, nack the last
        sdaHi = (bit_q != 4'h8) | (left_q == 8'h01);
      end
      default: begin
        sclHi = 1'b1;
        sdaHi = 1'b1;
      end
    endcase
    sclOe_d = ~sclHi;
    sdaOe_d = ~sdaHi;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= M_IDLE;
      op_q <= OP_WRITE;
      tick_q <= 8'h00;
      qtr_q <= 2'h0;
      bit_q <= 4'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      left_q <= 8'h00;
      wIdx_q <= 2'h0;
      chip_q <= 2'h0;
      rdPhase_q <= 1'b0;
      slvNack_q <= 1'b0;
      addr_q <= 15'h0000;
      data_q <= 8'h00;
      sclOe_q <= 1'b0;
      sdaOe_q <= 1'b0;
      rdValid <= 1'b0;
      rdData <= 8'h00;
      done <= 1'b0;
      nack <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      tick_q <= tick_d;
      qtr_q <= qtr_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      left_q <= left_d;
      wIdx_q <= wIdx_d;
      chip_q <= chip_d;
      rdPhase_q <= rdPhase_d;
      slvNack_q <= slvNack_d;
      addr_q <= addr_d;
      data_q <= data_d;
      sclOe_q <= sclOe_d;
      sdaOe_q <= sdaOe_d;
      rdValid <= rdValid_d;
      rdData <= rdData_d;
      done <= done_d;
      nack <= nack_d;
    end
  end

  assign link.sclOe = sclOe_q;
  assign link.sdaMasterOe = sdaOe_q;

endmodule

// [test/eeprom_link_assertions.sv]
// Purpose: concurrent checks on the two-wire link between both ends
// Assumes: both clock domains share one asynchronous rst_n
// Notes:   instantiated beside the link interface, no bind
`timescale 1ns/100ps
`include "eeprom_map.svh"
module eeprom_link_assertions #(
  parameter int unsigned WRITE_CYCLES = `EE_WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic linkClk,
  input wire logic rst_n,
  input wire logic sclOe,
  input wire logic sdaMasterOe,
  input wire logic sdaSlaveOe,
  input wire logic scl,
  input wire logic sda,
  input wire logic writeProtect,
  input wire logic programBusy
);
  // ----------------------------------------
  // busy length counter
  // ----------------------------------------
  logic [31:0] busyCnt_q;
  logic [31:0] busyCnt_d;
  always_comb begin
    busyCnt_d = programBusy ? busyCnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      busyCnt_q <= 32'h0;
    end else begin
      busyCnt_q <= busyCnt_d;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_busy_quiet;
    @(posedge linkClk) disable iff (!rst_n) programBusy |-> !sdaSlaveOe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("slave drives sda while busy");
  property p_wp_no_busy;
    @(posedge linkClk) disable iff (!rst_n) writeProtect |-> !$rose(programBusy);
  endproperty
  a_wp_no_busy: assert property (p_wp_no_busy)
    else $error("write cycle started while protected");
  // sync latency blurs the edge, so allow two cycles either way
  property p_busy_len;
    @(posedge linkClk) disable iff (!rst_n) $fell(programBusy) |->
      (busyCnt_q + 2 >= WRITE_CYCLES) && (busyCnt_q <= WRITE_CYCLES + 2);
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle length wrong");
  property p_slave_edge;
    @(posedge linkClk) disable iff (!rst_n)
      ($rose(sdaSlaveOe) || $fell(sdaSlaveOe)) |-> !scl;
  endproperty
  a_slave_edge: assert property (p_slave_edge)
    else $error("slave changed sda while scl high");
  property p_stop_release;
    @(posedge linkClk) disable iff (!rst_n) (scl && $rose(sda)) |-> !sdaSlaveOe [*8];
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("slave drives sda after stop");
  property p_start_release;
    @(posedge linkClk) disable iff (!rst_n) (scl && $fell(sda)) |-> !sdaSlaveOe [*4];
  endproperty
  a_start_release: assert property (p_start_release)
    else $error("slave drives sda after start");
  property p_scl_high;
    @(posedge clk) disable iff (!rst_n) $fell(sclOe) |-> !sclOe [*8];
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("scl high phase too short");
  property p_scl_low;
    @(posedge clk) disable iff (!rst_n) $rose(sclOe) |-> sclOe [*8];
  endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("scl low phase too short");
  c_busy: cover property (@(posedge linkClk) $rose(programBusy));
  c_slave_drive: cover property (@(posedge linkClk) $rose(sdaSlaveOe));
  c_master_ack: cover property (@(posedge clk) $rose(sdaMasterOe) && !scl);
endmodule

// [test/test_serial_eeprom_read_and_protect.sv]
// Purpose: both link ends joined, driven through the master command port
// Assumes: chip select pins tied to 2'b10
// Notes:   short write cycle so busy waits stay brief
`timescale 1ns/100ps
`include "eeprom_map.svh"
module test_serial_eeprom_read_and_protect
  import eeprom_pkg::*;
;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
    $display("Error %0t: got %h expected %h", $time, (a), (b)); end end
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst_n = 1'b0;
  logic writeProtect = 1'b0;
  logic programBusy;
  logic cmdValid = 1'b0;
  logic cmdReady;
  op_type cmdOp = OP_WRITE;
  logic [1:0] cmdChip = 2'h0;
  logic [`EE_ADDR_W-1:0] cmdAddr = '0;
  logic [7:0] cmdData = 8'h00;
  logic [7:0] cmdLen = 8'h00;
  logic rdValid;
  logic [7:0] rdData;
  logic done;
  logic nack;
  logic [7:0] rdQ[$];
  int err_count = 0;
  int checks_done = 0;
  eeprom_link_if eeprom_link_if_inst ();
  eeprom_master eeprom_master_inst (.clk(clk), .rst_n(rst_n), .link(eeprom_link_if_inst),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdChip(cmdChip),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdLen(cmdLen), .rdValid(rdValid),
    .rdData(rdData), .done(done), .nack(nack));
  eeprom_slave #(.WRITE_CYCLES(200)) eeprom_slave_inst (.linkClk(linkClk), .rst_n(rst_n),
    .link(eeprom_link_if_inst), .writeProtect(writeProtect), .chip_select_bit0(1'b0),
    .chip_select_bit1(1'b1), .programBusy(programBusy));
  eeprom_link_assertions #(.WRITE_CYCLES(200)) eeprom_link_assertions_inst (.clk(clk),
    .linkClk(linkClk), .rst_n(rst_n), .sclOe(eeprom_link_if_inst.sclOe),
    .sdaMasterOe(eeprom_link_if_inst.sdaMasterOe),
    .sdaSlaveOe(eeprom_link_if_inst.sdaSlaveOe), .scl(eeprom_link_if_inst.scl),
    .sda(eeprom_link_if_inst.sda), .writeProtect(writeProtect),
    .programBusy(programBusy));
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #3.1;
    forever #6 linkClk = ~linkClk;
  end
  // outputs are registers, so sample them away from the launching edge
  always @(negedge clk) begin
    if (rdValid === 1'b1) begin
      rdQ.push_back(rdData);
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic run_cmd(input op_type op, input logic [1:0] chip,
    input logic [`EE_ADDR_W-1:0] addr, input logic [7:0] data, input logic [7:0] len);
    logic ok;
    int n;
    rdQ.delete();
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdChip <= chip;
    cmdAddr <= addr;
    cmdData <= data;
    cmdLen <= len;
    do begin
      @(negedge clk);
      ok = (cmdReady === 1'b1);
      @(posedge clk);
    end while (!ok);
    cmdValid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      err_count++;
      $display("Error %0t: command never finished", $time);
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (20) @(posedge clk);
    while (programBusy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    `CHK(programBusy, 1'b0)
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    run_cmd(OP_WRITE, 2'h2, 15'h0001, 8'h5A, 8'h00);
    `CHK(nack, 1'b0)
    wait_idle();
    run_cmd(OP_WRITE, 2'h2, 15'h0000, 8'hC3, 8'h00);
    wait_idle();
    run_cmd(OP_WRITE, 2'h2, 15'h7FFF, 8'h3C, 8'h00);
    wait_idle();
    run_cmd(OP_RAND_READ, 2'h2, 15'h7FFF, 8'h00, 8'h03);
    `CHK(rdQ.size(), 3)
    `CHK(rdQ[0], 8'h3C)
    `CHK(rdQ[1], 8'hC3)
    `CHK(rdQ[2], 8'h5A)
    run_cmd(OP_RAND_READ, 2'h2, 15'h7FFF, 8'h00, 8'h01);
    `CHK(rdQ[0], 8'h3C)
    run_cmd(OP_CUR_READ, 2'h2, 15'h0000, 8'h00, 8'h02);
    `CHK(rdQ[0], 8'hC3)
    `CHK(rdQ[1], 8'h5A)
    // protected write: nack on data, nothing stored, no cycle
    @(posedge clk);
    writeProtect <= 1'b1;
    run_cmd(OP_WRITE, 2'h2, 15'h0000, 8'h00, 8'h00);
    `CHK(nack, 1'b1)
    repeat (300) @(posedge clk);
    `CHK(programBusy, 1'b0)
    // counter was 2 before; reading 0 shows the address bytes were taken
    run_cmd(OP_CUR_READ, 2'h2, 15'h0000, 8'h00, 8'h01);
    `CHK(rdQ[0], 8'hC3)
    @(posedge clk);
    writeProtect <= 1'b0;
    run_cmd(OP_RAND_READ, 2'h1, 15'h0000, 8'h00, 8'h01);
    `CHK(nack, 1'b1)
    run_cmd(OP_WRITE, 2'h2, 15'h0002, 8'h77, 8'h00);
    run_cmd(OP_CUR_READ, 2'h2, 15'h0000, 8'h00, 8'h01);
    `CHK(nack, 1'b1)
    wait_idle();
    run_cmd(OP_RAND_READ, 2'h2, 15'h0002, 8'h00, 8'h01);
    `CHK(nack, 1'b0)
    `CHK(rdQ[0], 8'h77)
    close_out();
  end
  // tests need about 45000 clk; allow a generous margin
  initial begin
    #600000;
    err_count++;
    $display("Error %0t: watchdog expired", $time);
    close_out();
  end
endmodule
